// *** include/pll_tally_pkg.sv ***
package pll_tally_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [11:0] unlock_tally_addr  = 12'h000;
    localparam logic [11:0] spare_config_addr  = 12'h004;
    localparam logic [11:0] spare_status_addr  = 12'h008;
    localparam logic [11:0] pll_status_addr    = 12'h00c;
    localparam logic [11:0] tally_thresh_addr  = 12'h010;

    localparam logic [3:0]  tally_reset        = 4'h0;
    localparam logic [3:0]  tally_max          = 4'hf;
    localparam logic [3:0]  thresh_reset       = 4'hf;
    localparam logic [15:0] spare_config_reset = 16'h0000;
    localparam logic [15:0] spare_config_mask  = 16'hffff;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int regulator_dis_bit = 15;
    localparam int sense_oneshot_bit = 13;
    localparam int gate_bypass_bit   = 12;
    localparam int gate_start_bit    = 11;
    localparam int bank_bypass_hi    = 10;
    localparam int bank_bypass_lo    = 4;
    localparam int lock_status_bit   = 0;
    localparam int limit_status_bit  = 1;

    localparam int sync_stages       = 3;

    typedef enum logic [3:0] {
        load_idle  = 4'b0001,
        load_wait  = 4'b0010,
        load_user  = 4'b0100,
        load_done  = 4'b1000
    } load_state_t;
endpackage

// *** logic/pin_sync.sv ***
module pin_sync #(
    parameter int width = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic [width-1:0] pin,
    output logic      [width-1:0] level
);
    logic [width-1:0] stage1;
    logic [width-1:0] stage2;
    logic [width-1:0] stage3;
    logic [width-1:0] next_level;

    // change is accepted once stages two and three agree
    always_comb
    begin
        for (int i = 0; i < width; i++)
        begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level  <= '0;
        end
        else if (clk_en)
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end
endmodule

// *** logic/pll_unlock_tally_analog_cfg.sv ***
module pll_unlock_tally_analog_cfg #(
    parameter int bank_count = 7
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pll_locked,
    input  wire logic        otp_common_last_valid,
    input  wire logic [7:0]  otp_common_last_byte,
    input  wire logic        vddo_all_present,
    output logic             user_config_load,
    output logic             regulator_group_off,
    output logic             vddo_sense_oneshot,
    output logic [bank_count-1:0] bank_ldo_bypass,
    output logic [3:0]       bandgap_ptat_adjust
);
    // ----------------------------------------
    // lock input and edge
    // ----------------------------------------
    logic lock_level;
    logic lock_prev;
    logic lock_fall;

    pin_sync #(
        .width(1)
    ) u_lock_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .pin     (pll_locked),
        .level   (lock_level)
    );

    assign lock_fall = lock_prev & ~lock_level;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic        wr_access;
    logic        rd_hit;
    logic [3:0]  tally;
    logic [3:0]  thresh;
    logic [15:0] spare_config;
    logic        limit_flag;
    logic [3:0]  next_tally;
    logic [3:0]  next_thresh;
    logic [15:0] next_spare_config;
    logic        next_limit_flag;
    logic [31:0] next_prdata;

    function automatic logic known_addr(input logic [11:0] a);
        known_addr = (a == pll_tally_pkg::unlock_tally_addr)
                  || (a == pll_tally_pkg::spare_config_addr)
                  || (a == pll_tally_pkg::spare_status_addr)
                  || (a == pll_tally_pkg::pll_status_addr)
                  || (a == pll_tally_pkg::tally_thresh_addr);
    endfunction

    assign pready    = 1'b1;
    assign wr_access = psel & penable & pwrite & clk_en;
    assign pslverr   = psel & penable & ~known_addr(paddr);
    assign rd_hit    = psel & ~penable & ~pwrite & clk_en;

    // ----------------------------------------
    // register next values
    // ----------------------------------------
    always_comb
    begin
        next_tally        = tally;
        next_thresh       = thresh;
        next_spare_config = spare_config;
        next_limit_flag   = limit_flag;
        if (lock_fall && tally != pll_tally_pkg::tally_max)
        begin
            next_tally = tally + 4'h1;
        end
        if (wr_access && paddr == pll_tally_pkg::unlock_tally_addr && pstrb[0])
        begin
            next_tally = pwdata[3:0];
        end
        if (wr_access && paddr == pll_tally_pkg::tally_thresh_addr && pstrb[0])
        begin
            next_thresh = pwdata[3:0];
        end
        if (wr_access && paddr == pll_tally_pkg::spare_config_addr)
        begin
            if (pstrb[0])
            begin
                next_spare_config[7:0] = pwdata[7:0];
            end
            if (pstrb[1])
            begin
                next_spare_config[15:8] = pwdata[15:8];
            end
        end
        // write one clears, but the live condition wins
        if (wr_access && paddr == pll_tally_pkg::pll_status_addr
            && pstrb[0] && pwdata[pll_tally_pkg::limit_status_bit])
        begin
            next_limit_flag = 1'b0;
        end
        if (next_tally > thresh)
        begin
            next_limit_flag = 1'b1;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_comb
    begin
        next_prdata = prdata;
        if (rd_hit)
        begin
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                pll_tally_pkg::unlock_tally_addr: next_prdata[3:0] = tally;
                pll_tally_pkg::spare_config_addr: next_prdata[15:0] = spare_config;
                pll_tally_pkg::tally_thresh_addr: next_prdata[3:0] = thresh;
                pll_tally_pkg::pll_status_addr:
                begin
                    next_prdata[pll_tally_pkg::lock_status_bit]  = lock_level;
                    next_prdata[pll_tally_pkg::limit_status_bit] = limit_flag;
                end
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_prev    <= 1'b0;
            tally        <= pll_tally_pkg::tally_reset;
            thresh       <= pll_tally_pkg::thresh_reset;
            spare_config <= pll_tally_pkg::spare_config_reset;
            limit_flag   <= 1'b0;
            prdata       <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            lock_prev    <= lock_level;
            tally        <= next_tally;
            thresh       <= next_thresh;
            spare_config <= next_spare_config;
            limit_flag   <= next_limit_flag;
            prdata       <= next_prdata;
        end
    end

    // ----------------------------------------
    // analog controls
    // ----------------------------------------
    assign regulator_group_off = spare_config[pll_tally_pkg::regulator_dis_bit];
    assign vddo_sense_oneshot  = spare_config[pll_tally_pkg::sense_oneshot_bit];
    assign bank_ldo_bypass     = spare_config[pll_tally_pkg::bank_bypass_hi:
                                              pll_tally_pkg::bank_bypass_lo];
    assign bandgap_ptat_adjust = spare_config[3:0];

    // ----------------------------------------
    // user config load gating
    // ----------------------------------------
    pll_tally_pkg::load_state_t load_state;
    pll_tally_pkg::load_state_t next_load_state;
    logic supplies_ok;
    logic gate_start;
    logic gate_bypass;

    pin_sync #(
        .width(1)
    ) u_vddo_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .pin     (vddo_all_present),
        .level   (supplies_ok)
    );

    // final common byte holds bits 15:8 of the config word
    assign gate_start  = otp_common_last_byte[pll_tally_pkg::gate_start_bit - 8];
    assign gate_bypass = otp_common_last_byte[pll_tally_pkg::gate_bypass_bit - 8];

    always_comb
    begin
        next_load_state = load_state;
        unique case (load_state)
            pll_tally_pkg::load_idle:
            begin
                if (otp_common_last_valid)
                begin
                    if (gate_start && !gate_bypass)
                    begin
                        next_load_state = pll_tally_pkg::load_wait;
                    end
                    else
                    begin
                        next_load_state = pll_tally_pkg::load_user;
                    end
                end
            end
            pll_tally_pkg::load_wait:
            begin
                if (supplies_ok)
                begin
                    next_load_state = pll_tally_pkg::load_user;
                end
            end
            pll_tally_pkg::load_user: next_load_state = pll_tally_pkg::load_done;
            pll_tally_pkg::load_done: next_load_state = pll_tally_pkg::load_done;
            default:                  next_load_state = pll_tally_pkg::load_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            load_state <= pll_tally_pkg::load_idle;
        end
        else if (clk_en)
        begin
            load_state <= next_load_state;
        end
    end

    assign user_config_load = (load_state == pll_tally_pkg::load_user);
endmodule

// *** tb/pll_tally_sva.sv ***
module pll_tally_sva #(
    parameter int bank_count = 7
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  clk_en,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  pll_locked,
    input wire logic                  otp_common_last_valid,
    input wire logic [7:0]            otp_common_last_byte,
    input wire logic                  vddo_all_present,
    input wire logic                  user_config_load,
    input wire logic                  regulator_group_off,
    input wire logic                  vddo_sense_oneshot,
    input wire logic [bank_count-1:0] bank_ldo_bypass,
    input wire logic [3:0]            bandgap_ptat_adjust
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // config write and read phases
    // ----------------------------------------
    sequence cfg_wr(logic [1:0] m);
        psel && penable && pwrite && clk_en && paddr == pll_tally_pkg::spare_config_addr
            && (pstrb[1:0] & m) == m;
    endsequence
    sequence rd_at(logic [11:0] a);
        psel && penable && !pwrite && paddr == a;
    endsequence
    a_trim_follow: assert property (cfg_wr(2'b01) |=> bandgap_ptat_adjust == $past(pwdata[3:0]))
        else $error("trim output wrong");
    a_trim_hold: assert property (!(psel && penable && pwrite) |=> $stable(bandgap_ptat_adjust))
        else $error("trim changed without write");
    a_regoff_follow: assert property (cfg_wr(2'b10) |=> regulator_group_off == $past(pwdata[15]))
        else $error("regulator off output wrong");
    a_sense_follow: assert property (cfg_wr(2'b10) |=> vddo_sense_oneshot == $past(pwdata[13]))
        else $error("sense select output wrong");
    a_bank_follow: assert property (cfg_wr(2'b11) |=> bank_ldo_bypass == $past(pwdata[10:4]))
        else $error("bank bypass output wrong");
    a_status_zero: assert property (rd_at(pll_tally_pkg::spare_status_addr) |-> prdata == 32'h0)
        else $error("spare status not zero");
    a_tally_upper: assert property (rd_at(pll_tally_pkg::unlock_tally_addr) |-> prdata[31:4] == 28'h0)
        else $error("tally upper bits not zero");
    a_load_single: assert property (user_config_load |=> !user_config_load [*4])
        else $error("user load repeated");
    a_slverr_map: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
        else $error("no error on unmapped address");
    a_freeze_hold: assert property (!clk_en |=> $stable(prdata) && $stable(bandgap_ptat_adjust)
        && $stable(bank_ldo_bypass) && $stable(regulator_group_off))
        else $error("state moved while clock enable low");
endmodule
bind pll_unlock_tally_analog_cfg pll_tally_sva #(.bank_count(bank_count)) u_sva (.*);

// *** tb/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pll_locked = 1'b1, otp_common_last_valid = 1'b0;
    logic        vddo_all_present = 1'b0, pready, pslverr, user_config_load, err;
    logic        regulator_group_off, vddo_sense_oneshot;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hf, bandgap_ptat_adjust;
    logic [7:0]  otp_common_last_byte = 8'h00;
    logic [6:0]  bank_ldo_bypass;
    int          n_mismatch = 0, n_tests = 0, n_load = 0, cyc = 0;

    pll_unlock_tally_analog_cfg DUT (.*);

    initial forever #20 pclk = ~pclk;
    // ----------------------------------------
    // watchdog and load pulse counter
    // ----------------------------------------
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (user_config_load === 1'b1) n_load++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            results();
        end
    end

    task results();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task lose();
        pll_locked <= 1'b0;
        repeat (8) @(posedge pclk);
        pll_locked <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        rdc(12'h000, 32'h0);
        rdc(12'h004, 32'h0);
        rdc(12'h008, 32'h0);
        rdc(12'h00c, 32'h1);
        $display("test 1 done");
        xfer(1'b1, 12'h004, 32'hffffffff);
        rdc(12'h004, 32'h0000ffff);
        chk({19'h0, regulator_group_off, vddo_sense_oneshot, bank_ldo_bypass, bandgap_ptat_adjust}, 32'h1fff);
        xfer(1'b1, 12'h004, 32'h00008a53);
        chk({19'h0, regulator_group_off, vddo_sense_oneshot, bank_ldo_bypass, bandgap_ptat_adjust}, 32'h1253);
        pstrb <= 4'h1;
        xfer(1'b1, 12'h004, 32'h0);
        pstrb <= 4'hf;
        rdc(12'h004, 32'h8a00);
        $display("test 2 done");
        xfer(1'b1, 12'h008, 32'hffff);
        rdc(12'h008, 32'h0);
        xfer(1'b1, 12'h020, 32'hffff);
        rdc(12'h020, 32'h0);
        chk(err, 1'b1);
        clk_en <= 1'b0;
        xfer(1'b1, 12'h004, 32'h0000_0001);
        clk_en <= 1'b1;
        rdc(12'h004, 32'h8a00);
        $display("test 3 done");
        pll_locked <= 1'b0;
        repeat (8) @(posedge pclk);
        rdc(12'h00c, 32'h0);
        pll_locked <= 1'b1;
        repeat (8) @(posedge pclk);
        rdc(12'h000, 32'h1);
        xfer(1'b1, 12'h010, 32'h2);
        lose();
        lose();
        rdc(12'h00c, 32'h3);
        xfer(1'b1, 12'h00c, 32'h2);
        rdc(12'h00c, 32'h3);
        repeat (13) lose();
        rdc(12'h000, 32'hf);
        xfer(1'b1, 12'h000, 32'h0);
        rdc(12'h000, 32'h0);
        xfer(1'b1, 12'h00c, 32'h2);
        rdc(12'h00c, 32'h1);
        xfer(1'b1, 12'h000, 32'hff);
        rdc(12'h000, 32'hf);
        xfer(1'b1, 12'h000, 32'he);
        lose();
        lose();
        rdc(12'h000, 32'hf);
        $display("test 4 done");
        otp_common_last_byte <= 8'h08;
        otp_common_last_valid <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(n_load, 0);
        vddo_all_present <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(n_load, 1);
        presetn <= 1'b0;
        otp_common_last_byte <= 8'h18;
        vddo_all_present <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(n_load, 2);
        rdc(12'h004, 32'h0);
        $display("test 5 done");
        results();
    end
endmodule
